// [common/sfp_pkg.sv]
package sfp_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_PRESCALE = 8'h10;
  // data port
  localparam int DATA_W = 16;
  // status bit positions
  localparam int ST_TFE = 0;
  localparam int ST_TNF = 1;
  localparam int ST_RNE = 2;
  localparam int ST_RFF = 3;
  localparam int ST_BSY = 4;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0003;
  // control register fields
  localparam int CTRL_SIZE_LSB = 0;
  localparam int CTRL_SIZE_W = 4;
  localparam int CTRL_EN_BIT = 4;
  localparam logic [3:0] SIZE_MIN_CODE = 4'h3;
  localparam logic [3:0] SIZE_RESET = 4'h7;
  // prescaler
  localparam int PRESC_W = 8;
  localparam logic [7:0] PRESC_RESET = 8'h00;
  localparam logic [7:0] PRESC_LSB_MASK = 8'hFE;
  // default fifo depth in entries
  localparam int FIFO_DEPTH = 8;
endpackage : sfp_pkg

// [rtl/sfp_port.sv]
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - data port carries 16 data bits; upper 16 read zero, read-only
// - reading data port returns rx FIFO head and pops it
// - each received frame value is written at the rx write pointer unless rx FIFO full
// - writing data port stores value at the tx write pointer unless tx FIFO full
// - tx values loaded one at a time into shifter, sent on mosi at bit rate
// - tx logic ignores upper unused bits for frames under 16 bits
// - rx values stored right-justified with upper bits zero
// - busy flag set while frame in flight or tx FIFO not empty
// - rx-full flag set when rx FIFO completely full
// - rx-not-empty flag set when rx FIFO holds an entry
// - tx-not-full flag set while tx FIFO has a free entry
// - tx-empty flag set when tx FIFO holds nothing
// - status resets to tx flags set, all else clear
// - 8-bit prescale divisor divides input clock before bit-rate use
// - prescale bit 0 hard-wired zero
// - prescale register at offset 0x10, resets to zero
// - 4-bit frame size code, 3..15 selects 4..16 bits
module sfp_port #(
  parameter int DEPTH = sfp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link, master side
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  output logic ss_n
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_CNT = CW'(1);
  localparam logic [AW-1:0] ONE_PTR = AW'(1);
  localparam logic [3:0] TOP_CODE = 4'hF;

  typedef enum logic [1:0] {SFP_IDLE, SFP_LEAD, SFP_TRAIL} sfp_state_t;

  // frame mask for a size code
  function automatic logic [15:0] sfp_mask(input logic [3:0] code);
    sfp_mask = 16'hFFFF >> (TOP_CODE - code);
  endfunction : sfp_mask

  logic [sfp_pkg::DATA_W-1:0] tx_mem [DEPTH];
  logic [sfp_pkg::DATA_W-1:0] rx_mem [DEPTH];
  logic [AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [CW-1:0] tx_cnt_q, rx_cnt_q;
  logic [3:0] size_q;
  logic en_q;
  logic [sfp_pkg::PRESC_W-1:0] presc_q;
  logic [sfp_pkg::PRESC_W-1:0] div_cnt_q;
  logic [15:0] tx_sh_q, rx_sh_q;
  logic [3:0] bit_q;
  sfp_state_t st_q;
  logic sclk_q, mosi_q;
  logic [31:0] prdata_q;

  logic acc, wr, rd, tick;
  logic tx_push, tx_pop, rx_push, rx_pop;
  logic tx_full, tx_empty, rx_full, rx_empty, busy;
  logic [4:0] status;
  logic [15:0] rx_word;
  logic hit_ctrl, hit_data, hit_presc;
  logic rise, fall, last_bit, shift_next;
  logic [15:0] tx_word;

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_q;

  assign tx_full = (tx_cnt_q == FULL_CNT);
  assign tx_empty = (tx_cnt_q == '0);
  assign rx_full = (rx_cnt_q == FULL_CNT);
  assign rx_empty = (rx_cnt_q == '0);
  assign busy = (st_q != SFP_IDLE) | ~tx_empty;

  always_comb begin
    status = '0;
    status[sfp_pkg::ST_BSY] = busy;
    status[sfp_pkg::ST_RFF] = rx_full;
    status[sfp_pkg::ST_RNE] = ~rx_empty;
    status[sfp_pkg::ST_TNF] = ~tx_full;
    status[sfp_pkg::ST_TFE] = tx_empty;
  end

  assign hit_ctrl = (paddr == sfp_pkg::ADDR_CTRL);
  assign hit_data = (paddr == sfp_pkg::ADDR_DATA);
  assign hit_presc = (paddr == sfp_pkg::ADDR_PRESCALE);
  assign tx_push = wr & hit_data & ~tx_full;
  assign rx_pop = rd & hit_data & ~rx_empty;

  // control register: frame size and enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      size_q <= sfp_pkg::SIZE_RESET;
      en_q <= 1'b0;
    end else if (wr & hit_ctrl) begin
      size_q <= pwdata[sfp_pkg::CTRL_SIZE_LSB +: sfp_pkg::CTRL_SIZE_W];
      en_q <= pwdata[sfp_pkg::CTRL_EN_BIT];
    end
  end

  // prescale register, bit 0 never stored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      presc_q <= sfp_pkg::PRESC_RESET;
    end else if (wr & hit_presc) begin
      presc_q <= pwdata[sfp_pkg::PRESC_W-1:0] & sfp_pkg::PRESC_LSB_MASK;
    end
  end

  // read data, registered on the setup cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_q <= '0;
    end else if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        sfp_pkg::ADDR_CTRL: prdata_q <= {27'h0, en_q, size_q};
        sfp_pkg::ADDR_DATA: prdata_q <= {16'h0, rx_empty ? 16'h0 : rx_mem[rx_rp_q]};
        sfp_pkg::ADDR_STATUS: prdata_q <= {27'h0, status};
        sfp_pkg::ADDR_PRESCALE: prdata_q <= {24'h0, presc_q};
        default: prdata_q <= '0;
      endcase
    end
  end

  // transmit FIFO
  always_ff @(posedge ref_clk) begin
    if (tx_push) begin
      tx_mem[tx_wp_q] <= pwdata[sfp_pkg::DATA_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
    end else begin
      if (tx_push) tx_wp_q <= tx_wp_q + ONE_PTR;
      if (tx_pop) tx_rp_q <= tx_rp_q + ONE_PTR;
    end
  end

  // tx fill level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_cnt_q <= '0;
    end else if (tx_push & ~tx_pop) begin
      tx_cnt_q <= tx_cnt_q + ONE_CNT;
    end else if (tx_pop & ~tx_push) begin
      tx_cnt_q <= tx_cnt_q - ONE_CNT;
    end
  end

  // receive FIFO
  always_ff @(posedge ref_clk) begin
    if (rx_push) begin
      rx_mem[rx_wp_q] <= rx_word;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
    end else begin
      if (rx_push) rx_wp_q <= rx_wp_q + ONE_PTR;
      if (rx_pop) rx_rp_q <= rx_rp_q + ONE_PTR;
    end
  end

  // rx fill level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_cnt_q <= '0;
    end else if (rx_push & ~rx_pop) begin
      rx_cnt_q <= rx_cnt_q + ONE_CNT;
    end else if (rx_pop & ~rx_push) begin
      rx_cnt_q <= rx_cnt_q - ONE_CNT;
    end
  end

  // prescaler: one tick every presc_q input clocks
  assign tick = (st_q != SFP_IDLE) &
    ((div_cnt_q + 8'h01) >= presc_q) & (presc_q != '0);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= '0;
    end else if (st_q == SFP_IDLE || tick) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // shift engine
  assign tx_pop = (st_q == SFP_IDLE) & en_q & ~tx_empty & (presc_q != '0);
  assign rise = (st_q == SFP_LEAD) & tick;
  assign fall = (st_q == SFP_TRAIL) & tick;
  assign last_bit = fall & (bit_q == '0);
  assign shift_next = fall & (bit_q != '0);
  assign tx_word = tx_mem[tx_rp_q] & sfp_mask(size_q);
  assign rx_push = last_bit & ~rx_full;
  assign rx_word = rx_sh_q & sfp_mask(size_q);

  // frame sequencing
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= SFP_IDLE;
    end else begin
      unique case (st_q)
        SFP_IDLE: begin
          if (tx_pop) begin
            st_q <= SFP_LEAD;
          end
        end
        SFP_LEAD: begin
          if (rise) begin
            st_q <= SFP_TRAIL;
          end
        end
        SFP_TRAIL: begin
          if (last_bit) begin
            st_q <= SFP_IDLE;
          end else if (fall) begin
            st_q <= SFP_LEAD;
          end
        end
        default: st_q <= SFP_IDLE;
      endcase
    end
  end

  // bits still to send in the frame after the current one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_q <= '0;
    end else if (tx_pop) begin
      bit_q <= size_q;
    end else if (shift_next) begin
      bit_q <= bit_q - 4'h1;
    end
  end

  // transmit shifter, frame msb aligned to bit 15
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_sh_q <= '0;
    end else if (tx_pop) begin
      tx_sh_q <= tx_word << (TOP_CODE - size_q);
    end else if (shift_next) begin
      tx_sh_q <= {tx_sh_q[14:0], 1'b0};
    end
  end

  // serial data out, loaded at frame start, then moves only as sclk falls
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mosi_q <= 1'b0;
    end else if (tx_pop) begin
      mosi_q <= tx_word[size_q];
    end else if (shift_next) begin
      mosi_q <= tx_sh_q[14];
    end
  end

  // receive shifter, samples miso as sclk rises
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_sh_q <= '0;
    end else if (tx_pop) begin
      rx_sh_q <= '0;
    end else if (rise) begin
      rx_sh_q <= {rx_sh_q[14:0], miso};
    end
  end

  // serial clock, low outside frames
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else if (rise) begin
      sclk_q <= 1'b1;
    end else if (fall) begin
      sclk_q <= 1'b0;
    end
  end

  assign sclk = sclk_q;
  assign mosi = mosi_q;
  assign ss_n = (st_q == SFP_IDLE);
endmodule : sfp_port

// [verification/sfp_port_asserts.sv]
`timescale 1ns/1ps
module sfp_port_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  // serial
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic rd;
  logic st;
  assign rd = psel && penable && !pwrite;
  assign st = rd && paddr == sfp_pkg::ADDR_STATUS;
  sequence s_sclk_high;
    sclk ##1 sclk;
  endsequence
  a_data_upper: assert property (rd && paddr == sfp_pkg::ADDR_DATA |-> prdata[31:16] == 16'h0)
    else $error("data upper bits set");
  a_presc_even: assert property (rd && paddr == sfp_pkg::ADDR_PRESCALE |-> prdata[31:8] == 24'h0 && !prdata[0])
    else $error("prescale bits wrong");
  a_status_rsvd: assert property (st |-> prdata[31:5] == 27'h0)
    else $error("status reserved set");
  a_busy_tx: assert property (st && !prdata[sfp_pkg::ST_TFE] |-> prdata[sfp_pkg::ST_BSY])
    else $error("busy low with tx data");
  a_busy_frame: assert property (st && !ss_n |-> prdata[sfp_pkg::ST_BSY])
    else $error("busy low in frame");
  a_full_ne: assert property (st && prdata[sfp_pkg::ST_RFF] |-> prdata[sfp_pkg::ST_RNE])
    else $error("rx full but empty");
  a_tx_flags: assert property (st && prdata[sfp_pkg::ST_TFE] |-> prdata[sfp_pkg::ST_TNF])
    else $error("tx empty but full");
  a_sclk_idle: assert property (ss_n |-> !sclk)
    else $error("sclk out of frame");
  a_mosi_hold: assert property (s_sclk_high |-> $stable(mosi))
    else $error("mosi moved while sclk high");
endmodule : sfp_port_asserts
bind sfp_port sfp_port_asserts u_chk (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
  .prdata, .sclk, .mosi, .ss_n);

// [verification/sfp_slave_model.sv]
`timescale 1ns/1ps
module sfp_slave_model (
  // serial link
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  output logic miso,
  // reply and capture
  input wire logic [15:0] reply,
  input wire logic [4:0] nbits,
  output logic [15:0] got
);
  int idx = 0;
  initial miso = 1'b0;
  initial got = 16'h0000;
  always @(negedge ss_n) begin
    idx = nbits - 1;
    miso = reply[idx];
    got = 16'h0000;
  end
  always @(posedge sclk) got = {got[14:0], mosi};
  always @(negedge sclk) begin
    if (!ss_n && idx > 0) begin
      idx = idx - 1;
      miso = reply[idx];
    end
  end
  // released line must not keep the last bit
  always @(posedge ss_n) miso = ~miso;
endmodule : sfp_slave_model

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  localparam int DEPTH = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sclk, mosi, miso, ss_n;
  logic [15:0] reply = 16'h0000, got;
  logic [4:0] nbits = 5'h08;
  int errors = 0, n_tests = 0;
  always #5 ref_clk = ~ref_clk;
  sfp_port #(.DEPTH(DEPTH)) dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sclk, .mosi, .miso, .ss_n);
  sfp_slave_model slave (.sclk, .mosi, .ss_n, .miso, .reply, .nbits, .got);
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    if (pslverr !== 1'b0) begin
      errors++;
      $display("Error pslverr expected 0 seen %b", pslverr);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rchk
  task automatic wait_idle;
    rd = 32'h10;
    for (int n = 0; n < 200 && rd[4] !== 1'b0; n++) apb(1'b0, sfp_pkg::ADDR_STATUS, 32'h0);
    chk("busy clear", 32'h0, {31'h0, rd[4]});
  endtask : wait_idle
  task automatic t_reset;
    rchk(sfp_pkg::ADDR_STATUS, 32'h03, "status");
    rchk(sfp_pkg::ADDR_PRESCALE, 32'h00, "prescale");
    rchk(sfp_pkg::ADDR_DATA, 32'h00, "empty read");
    $display("reset test done");
  endtask : t_reset
  task automatic t_prescale;
    apb(1'b1, sfp_pkg::ADDR_PRESCALE, 32'hFFFF_FF25);
    rchk(sfp_pkg::ADDR_PRESCALE, 32'h24, "prescale odd");
    apb(1'b1, 8'h40, 32'h5A);
    rchk(8'h40, 32'h0, "unmapped");
    apb(1'b1, sfp_pkg::ADDR_PRESCALE, 32'h02);
    $display("prescale test done");
  endtask : t_prescale
  task automatic t_frame;
    reply <= 16'hFFBC;
    apb(1'b1, sfp_pkg::ADDR_CTRL, 32'h17);
    rchk(sfp_pkg::ADDR_CTRL, 32'h17, "ctrl");
    apb(1'b1, sfp_pkg::ADDR_DATA, 32'hFFFF_01A5);
    wait_idle();
    chk("mosi word", 32'hA5, {16'h0, got});
    rchk(sfp_pkg::ADDR_DATA, 32'hBC, "rx word");
    rchk(sfp_pkg::ADDR_STATUS, 32'h03, "idle");
    reply <= 16'hC35A;
    nbits <= 5'h10;
    apb(1'b1, sfp_pkg::ADDR_CTRL, 32'h1F);
    apb(1'b1, sfp_pkg::ADDR_DATA, 32'h0000_8001);
    wait_idle();
    chk("mosi word 16", 32'h8001, {16'h0, got});
    rchk(sfp_pkg::ADDR_DATA, 32'hC35A, "rx word 16");
    $display("frame test done");
  endtask : t_frame
  task automatic t_fill;
    apb(1'b1, sfp_pkg::ADDR_CTRL, 32'h03);
    for (int i = 0; i <= DEPTH; i++) apb(1'b1, sfp_pkg::ADDR_DATA, i + 1);
    rchk(sfp_pkg::ADDR_STATUS, 32'h10, "tx full");
    reply <= 16'h0009;
    nbits <= 5'h04;
    apb(1'b1, sfp_pkg::ADDR_CTRL, 32'h13);
    wait_idle();
    chk("last frame", DEPTH, {16'h0, got});
    rchk(sfp_pkg::ADDR_STATUS, 32'h0F, "rx full");
    for (int i = 0; i < DEPTH; i++) rchk(sfp_pkg::ADDR_DATA, 32'h9, "rx entry");
    rchk(sfp_pkg::ADDR_DATA, 32'h0, "underflow");
    rchk(sfp_pkg::ADDR_STATUS, 32'h03, "drained");
    $display("fill test done");
  endtask : t_fill
  task automatic t_midreset;
    apb(1'b1, sfp_pkg::ADDR_DATA, 32'h6);
    repeat (4) @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rchk(sfp_pkg::ADDR_STATUS, 32'h03, "status after reset");
    rchk(sfp_pkg::ADDR_PRESCALE, 32'h00, "prescale after reset");
    rchk(sfp_pkg::ADDR_CTRL, 32'h07, "ctrl after reset");
    $display("mid-run reset test done");
  endtask : t_midreset
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_prescale();
    t_frame();
    t_fill();
    t_midreset();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    report_and_stop();
  end
endmodule : tb_top
